// ### src/scpi_pkg.sv
`default_nettype none
package scpi_pkg;
	// ========================================
	// Register map (byte addresses)
	localparam logic [7:0] OPER_COND = 8'h00;
	localparam logic [7:0] OPER_PTR = 8'h04;
	localparam logic [7:0] OPER_NTR = 8'h08;
	localparam logic [7:0] OPER_EVENT = 8'h0c;
	localparam logic [7:0] OPER_ENABLE = 8'h10;
	localparam logic [7:0] QUES_COND = 8'h20;
	localparam logic [7:0] QUES_PTR = 8'h24;
	localparam logic [7:0] QUES_NTR = 8'h28;
	localparam logic [7:0] QUES_EVENT = 8'h2c;
	localparam logic [7:0] QUES_ENABLE = 8'h30;
	localparam logic [7:0] STD_EVENT = 8'h40;
	localparam logic [7:0] STD_ENABLE = 8'h44;
	localparam logic [7:0] STB_READ = 8'h48;
	localparam logic [7:0] SRQ_ENABLE = 8'h4c;
	// ========================================
	// Reset values and field positions
	localparam logic [15:0] PTR_RST = 16'h7fff;
	localparam logic [15:0] NTR_RST = 16'h0000;
	localparam logic [15:0] ENA_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] PART_MASK = 16'h7fff;
	localparam int OPER_CAL_BIT = 0;
	localparam int STB_ERRQ_BIT = 2;
	localparam int STB_QUES_BIT = 3;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MSS_BIT = 6;
	localparam int STB_OPER_BIT = 7;
endpackage
`default_nettype wire

// ### src/scpi_status_reg.sv
`default_nettype none
module scpi_status_reg
	import scpi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] cond,
	input wire logic wr_ptr,
	input wire logic wr_ntr,
	input wire logic wr_ena,
	input wire logic [15:0] wdata,
	input wire logic rd_event,
	output logic [15:0] cond_q,
	output logic [15:0] ptr_q,
	output logic [15:0] ntr_q,
	output logic [15:0] event_q,
	output logic [15:0] ena_q,
	output logic sum
);
	// ========================================
	// One five-part register, bit 15 forced to zero.
	logic [15:0] prev_r;
	logic [15:0] ptr_r;
	logic [15:0] ntr_r;
	logic [15:0] ena_r;
	logic [15:0] event_r;
	logic [15:0] cond_m;
	logic [15:0] edge_set;

	assign cond_m = cond & PART_MASK;
	assign edge_set = ((cond_m & ~prev_r) & ptr_r) | ((~cond_m & prev_r) & ntr_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 16'h0000;
		end else begin
			prev_r <= cond_m;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_r <= PTR_RST;
			ntr_r <= NTR_RST;
			ena_r <= ENA_RST;
		end else begin
			if (wr_ptr) begin
				ptr_r <= wdata & PART_MASK;
			end
			if (wr_ntr) begin
				ntr_r <= wdata & PART_MASK;
			end
			if (wr_ena) begin
				ena_r <= wdata & PART_MASK;
			end
		end
	end

	// A read clears only what was seen; a new edge in the same cycle survives.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_r <= 16'h0000;
		end else if (rd_event) begin
			event_r <= edge_set;
		end else begin
			event_r <= event_r | edge_set;
		end
	end

	assign cond_q = cond_m;
	assign ptr_q = ptr_r;
	assign ntr_q = ntr_r;
	assign event_q = event_r;
	assign ena_q = ena_r;
	assign sum = |(event_r & ena_r);
endmodule
`default_nettype wire

// ### src/scpi_status_reporting.sv
`default_nettype none
module scpi_status_reporting
	import scpi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] oper_cond_in,
	input wire logic [15:0] ques_cond_in,
	input wire logic [7:0] std_event_in,
	input wire logic cal_busy,
	input wire logic error_queue_nonempty,
	input wire logic msg_available,
	output logic srq,
	output logic [7:0] status_byte
);
	// ========================================
	// Bus decode
	logic wr;
	logic rd;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ========================================
	// Operation and questionable registers
	logic [15:0] oper_cond;
	logic [15:0] op_c;
	logic [15:0] op_p;
	logic [15:0] op_n;
	logic [15:0] op_e;
	logic [15:0] op_en;
	logic op_sum;
	logic [15:0] qu_c;
	logic [15:0] qu_p;
	logic [15:0] qu_n;
	logic [15:0] qu_e;
	logic [15:0] qu_en;
	logic qu_sum;

	always_comb begin
		oper_cond = oper_cond_in;
		oper_cond[OPER_CAL_BIT] = cal_busy;
	end

	scpi_status_reg u_oper (
		.pclk(pclk),
		.presetn(presetn),
		.cond(oper_cond),
		.wr_ptr(wr && hit(paddr, OPER_PTR)),
		.wr_ntr(wr && hit(paddr, OPER_NTR)),
		.wr_ena(wr && hit(paddr, OPER_ENABLE)),
		.wdata(pwdata[15:0]),
		.rd_event(rd && hit(paddr, OPER_EVENT)),
		.cond_q(op_c),
		.ptr_q(op_p),
		.ntr_q(op_n),
		.event_q(op_e),
		.ena_q(op_en),
		.sum(op_sum)
	);

	scpi_status_reg u_ques (
		.pclk(pclk),
		.presetn(presetn),
		.cond(ques_cond_in),
		.wr_ptr(wr && hit(paddr, QUES_PTR)),
		.wr_ntr(wr && hit(paddr, QUES_NTR)),
		.wr_ena(wr && hit(paddr, QUES_ENABLE)),
		.wdata(pwdata[15:0]),
		.rd_event(rd && hit(paddr, QUES_EVENT)),
		.cond_q(qu_c),
		.ptr_q(qu_p),
		.ntr_q(qu_n),
		.event_q(qu_e),
		.ena_q(qu_en),
		.sum(qu_sum)
	);

	// ========================================
	// Standard event status register and its enable
	logic [7:0] std_ev_r;
	logic [7:0] std_en_r;
	logic esb;

	// Inputs are single-cycle event pulses; a pulse during the clearing read wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_ev_r <= BYTE_RST;
		end else if (rd && hit(paddr, STD_EVENT)) begin
			std_ev_r <= std_event_in;
		end else begin
			std_ev_r <= std_ev_r | std_event_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_en_r <= BYTE_RST;
		end else if (wr && hit(paddr, STD_ENABLE)) begin
			std_en_r <= pwdata[7:0];
		end
	end

	assign esb = |(std_ev_r & std_en_r);

	// ========================================
	// Status byte and service request
	logic [7:0] sre_r;
	logic [7:0] stb_low;
	logic [7:0] stb;
	logic [7:0] enabled;
	logic [7:0] enabled_prev_r;
	logic mss;

	always_comb begin
		stb_low = 8'h00;
		stb_low[STB_ERRQ_BIT] = error_queue_nonempty;
		stb_low[STB_QUES_BIT] = qu_sum;
		stb_low[STB_MAV_BIT] = msg_available;
		stb_low[STB_ESB_BIT] = esb;
		stb_low[STB_OPER_BIT] = op_sum;
	end

	assign enabled = stb_low & sre_r;
	assign mss = |enabled;

	always_comb begin
		stb = stb_low;
		stb[STB_MSS_BIT] = mss;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sre_r <= BYTE_RST;
		end else if (wr && hit(paddr, SRQ_ENABLE)) begin
			sre_r <= pwdata[7:0] & ~(8'h01 << STB_MSS_BIT);
		end
	end

	// Edge-triggered so a standing enabled bit does not repeat the request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enabled_prev_r <= BYTE_RST;
			srq <= 1'b0;
			status_byte <= BYTE_RST;
		end else begin
			enabled_prev_r <= enabled;
			srq <= |(enabled & ~enabled_prev_r);
			status_byte <= stb;
		end
	end

	// ========================================
	// Read mux and error response
	logic [31:0] rdata_nxt;
	logic mapped;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			OPER_COND: rdata_nxt[15:0] = op_c;
			OPER_PTR: rdata_nxt[15:0] = op_p;
			OPER_NTR: rdata_nxt[15:0] = op_n;
			OPER_EVENT: rdata_nxt[15:0] = op_e;
			OPER_ENABLE: rdata_nxt[15:0] = op_en;
			QUES_COND: rdata_nxt[15:0] = qu_c;
			QUES_PTR: rdata_nxt[15:0] = qu_p;
			QUES_NTR: rdata_nxt[15:0] = qu_n;
			QUES_EVENT: rdata_nxt[15:0] = qu_e;
			QUES_ENABLE: rdata_nxt[15:0] = qu_en;
			STD_EVENT: rdata_nxt[7:0] = std_ev_r;
			STD_ENABLE: rdata_nxt[7:0] = std_en_r;
			STB_READ: rdata_nxt[7:0] = stb;
			SRQ_ENABLE: rdata_nxt[7:0] = sre_r;
			default: mapped = 1'b0;
		endcase
	end

	// Writes to read-only addresses are accepted silently; only unmapped ones error.
	assign prdata = rdata_nxt;
	assign pslverr = psel && penable && !mapped;
endmodule
`default_nettype wire

// ### dv/scpi_sr_chk_sva.sv
`default_nettype none
module scpi_sr_chk
	import scpi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] oper_cond_in,
	input wire logic [15:0] ques_cond_in,
	input wire logic [7:0] std_event_in,
	input wire logic cal_busy,
	input wire logic error_queue_nonempty,
	input wire logic msg_available,
	input wire logic srq,
	input wire logic [7:0] status_byte
);
	// ========
	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic rd = psel && penable && !pwrite;
	wire logic rq = rd && paddr == QUES_COND;
	wire logic ro = rd && paddr == OPER_COND;
	wire logic re = rd && paddr == STD_EVENT;
	property p_b15; rd |-> prdata[31:15] == 17'h0; endproperty
	a_b15: assert property (p_b15) else $error("high bits set");
	property p_qc; rq && $stable(ques_cond_in) |-> prdata[14:0] == ques_cond_in[14:0]; endproperty
	a_qc: assert property (p_qc) else $error("cond mismatch");
	property p_oc; ro && $stable(cal_busy) |-> prdata[0] == cal_busy; endproperty
	a_oc: assert property (p_oc) else $error("cal bit mismatch");
	property p_sb; $past(presetn) |-> status_byte[4] == $past(msg_available)
		&& status_byte[2] == $past(error_queue_nonempty); endproperty
	a_sb: assert property (p_sb) else $error("byte bits wrong");
	property p_mss; status_byte[6] |-> (status_byte & 8'hbc) != 8'h00; endproperty
	a_mss: assert property (p_mss) else $error("summary alone");
	property p_srq; srq |-> ##[0:1] status_byte[6]; endproperty
	a_srq: assert property (p_srq) else $error("request no summary");
	property p_clr; re && std_event_in == 8'h00 ##1 std_event_in == 8'h00 [*2] ##1 re
		|-> prdata[7:0] == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("event not cleared");
	property p_keep; re && std_event_in[1] ##3 re |-> prdata[1]; endproperty
	a_keep: assert property (p_keep) else $error("event lost");
	c_srq: cover property (srq);
	c_keep: cover property (re && std_event_in[1]);
	c_err: cover property (psel && penable && pslverr);
endmodule
bind scpi_status_reporting scpi_sr_chk u_chk (.*);
`default_nettype wire

// ### dv/scpi_status_reporting_test.sv
`default_nettype none
module scpi_status_reporting_test import scpi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic cal_busy = 1'h0, error_queue_nonempty = 1'h0, msg_available = 1'h0;
	logic [7:0] paddr = 8'h0, std_event_in = 8'h0, status_byte;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [15:0] oper_cond_in = 16'h0, ques_cond_in = 16'h0;
	logic pready, pslverr, srq, eq;
	int n_mismatch = 0, compares = 0, nsrq = 0;
	scpi_status_reporting dut (.*);
	// ========
	// Clock and helpers
	initial begin
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) if (srq === 1'h1) nsrq <= nsrq + 1;
	task finish_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	// The slave answers at once, but the wait stays bounded in case it never does.
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		q = prdata;
		eq = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'h1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'h0, a, 32'h0);
		chk(q, e);
	endtask
	// ========
	// Tests
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rd(OPER_PTR, 32'h7fff);
		rd(OPER_NTR, 32'h0);
		rd(OPER_ENABLE, 32'h0);
		rd(STB_READ, 32'h0);
		$display("reset test done");
		wr(QUES_PTR, 32'hffffffff);
		wr(QUES_NTR, 32'hffffffff);
		wr(QUES_ENABLE, 32'hffffffff);
		wr(STD_ENABLE, 32'hffffffff);
		wr(SRQ_ENABLE, 32'hffffffff);
		for (int i = 0; i < 2; i++) begin
			rd(QUES_PTR, 32'h7fff);
			rd(QUES_NTR, 32'h7fff);
			rd(QUES_ENABLE, 32'h7fff);
			rd(STD_ENABLE, 32'hff);
			rd(SRQ_ENABLE, 32'hbf);
		end
		$display("access test done");
		oper_cond_in <= 16'h8a50;
		cal_busy <= 1'h1;
		wr(OPER_COND, 32'h0);
		rd(OPER_COND, 32'h0a51);
		$display("condition test done");
		wr(QUES_PTR, 32'h1);
		wr(QUES_NTR, 32'h2);
		wr(QUES_ENABLE, 32'h2);
		wr(SRQ_ENABLE, 32'h8);
		ques_cond_in <= 16'h0003;
		repeat (3) @(posedge pclk);
		rd(QUES_EVENT, 32'h1);
		ques_cond_in <= 16'h0000;
		repeat (3) @(posedge pclk);
		rd(STB_READ, 32'h48);
		rd(QUES_EVENT, 32'h2);
		rd(QUES_EVENT, 32'h0);
		rd(STB_READ, 32'h0);
		chk(nsrq, 32'h1);
		$display("filter test done");
		wr(STD_ENABLE, 32'h2);
		fork
			rd(STD_EVENT, 32'h0);
			begin
				repeat (2) @(posedge pclk);
				std_event_in <= 8'h02;
				@(posedge pclk);
				std_event_in <= 8'h00;
			end
		join
		rd(STD_EVENT, 32'h2);
		rd(STD_EVENT, 32'h0);
		$display("event test done");
		msg_available <= 1'h1;
		error_queue_nonempty <= 1'h1;
		wr(SRQ_ENABLE, 32'h10);
		rd(STB_READ, 32'h54);
		chk({24'h0, status_byte}, 32'h54);
		chk(nsrq, 32'h2);
		acc(1'h0, 8'h80, 32'h0);
		chk({31'h0, eq}, 32'h1);
		$display("byte test done");
		finish_test();
	end
endmodule
`default_nettype wire
